// ===== bmrc_map.vh
`ifndef BMRC_MAP_VH
`define BMRC_MAP_VH
// Register index (word addresses on the plain port)
`define BMRC_ADDR_W          4
`define BMRC_REG_SYSCFG      4'h0
`define BMRC_REG_STATUS      4'h1
`define BMRC_REG_CTRL        4'h2
`define BMRC_REG_DECODE      4'h3
// System configuration register fields
`define BMRC_BUS_ACTIVE_STRAP_N_BIT      10
`define BMRC_BUS_TYPE_FIELD_LO         7
`define BMRC_BUS_TYPE_FIELD_HI         8
`define BMRC_SYSCFG_RST      16'h0000
// Control register: bit 0 marks end of init, bit 1 a code branch
`define BMRC_CTRL_END_OF_INIT_INSTRUCTION_BIT  0
`define BMRC_CTRL_BRANCH_BIT 1
// Bus type encodings
`define BMRC_BT_8NMUX        2'h0
`define BMRC_BT_8MUX         2'h1
`define BMRC_BT_16MUX        2'h2
`define BMRC_BT_16NMUX       2'h3
// ROM placement encodings
`define BMRC_ROM_SEG0        2'h0
`define BMRC_ROM_SEG1        2'h1
`define BMRC_ROM_OFF         2'h2
// Segment 1 ROM window, 8 Kbyte
`define BMRC_SEG1_LO         18'h10000
`define BMRC_SEG1_HI         18'h11fff
`define BMRC_SEG0_HI         18'h01fff
// Data map delay in instructions (second instruction after the write)
`define BMRC_DATA_LAG        2'h2
`endif

// ===== bmrc_strap_cap.v
`timescale 1ns/10ps
`include "bmrc_map.vh"
module bmrc_strap_cap
(
   // Clock and reset
   input  wire       i_ref_clk,
   input  wire       i_rstn,
   // Strap pins
   input  wire       i_bus_active_strap_n,
   input  wire       i_bus_cfg_strap0,
   input  wire       i_bus_cfg_strap1,
   // Captured straps
   output reg        o_bus_active_strap_n_ff,
   output reg  [1:0] o_bus_type_field_ff,
   output reg        o_load_ff
);
   reg               rst_d_ff;

   // Straps are taken on the first edge with reset released
   always @(posedge i_ref_clk)
   begin
      rst_d_ff <= i_rstn;
      if (!i_rstn)
      begin
         o_bus_active_strap_n_ff <= 1'b0;
         o_bus_type_field_ff   <= 2'h0;
         o_load_ff   <= 1'b0;
      end
      else if (!rst_d_ff)
      begin
         o_bus_active_strap_n_ff <= ~i_bus_active_strap_n;
         o_bus_type_field_ff   <= {i_bus_cfg_strap1, i_bus_cfg_strap0};
         o_load_ff   <= 1'b1;
      end
      else
      begin
         o_load_ff   <= 1'b0;
      end
   end
endmodule

// ===== bmrc_rom_decode.v
`timescale 1ns/10ps
`include "bmrc_map.vh"
module bmrc_rom_decode
(
   // Mapping and address
   input  wire [1:0]  i_rom_map,
   input  wire [17:0] i_addr,
   // Result
   output wire        o_rom_hit
);
   // Segment 1 window is 10000h..11fffh, segment 0 window 0..1fffh
   assign o_rom_hit = (i_rom_map == `BMRC_ROM_SEG1) ?
                      ((i_addr >= `BMRC_SEG1_LO) && (i_addr <= `BMRC_SEG1_HI)) :
                      (i_rom_map == `BMRC_ROM_SEG0) ? (i_addr <= `BMRC_SEG0_HI) : 1'b0;
endmodule

// ===== bmrc_config.v
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`include "bmrc_map.vh"
// Functional notes
// - Data map changes from second later instruction
// - Code map changes at absolute branch
// - Segment 1 ROM spans 10000h to 11FFFh
// - Strap high boots internal ROM, ignores cfg
// - Reserved strap combos still give single chip
// - Strap low boots external with strap mode
// - Cfg 00,01,10,11 give four bus modes
// - Bit 10 loads inverted bus-active strap
// - Bus type field loads cfg straps
// - Bus-active and bus type always read/write
// - ROM changes only before end of init
// - Active 0 type 01 segment1, 00 segment0
// - Type 10 ROM off, 11 bus off, both only before end of init
// - Bus mode changes only with active 1
// - Active 1 selects bus mode always
module bmrc_config
(
   // Clock and reset
   input  wire        i_ref_clk,
   input  wire        i_rstn,
   // Strap pins
   input  wire        i_bus_active_strap_n,
   input  wire        i_bus_cfg_strap0,
   input  wire        i_bus_cfg_strap1,
   // Register port
   input  wire [3:0]  i_addr,
   input  wire [15:0] i_wdata,
   input  wire        i_wr,
   input  wire        i_rd,
   output reg  [15:0] o_rdata,
   // Instruction progress from the core
   input  wire        i_instr_done,
   // Address lookups
   input  wire [17:0] i_data_addr,
   input  wire [17:0] i_code_addr,
   // Resulting configuration
   output reg         o_boot_internal_ff,
   output reg         o_ext_bus_en_ff,
   output reg  [1:0]  o_bus_mode_ff,
   output reg  [1:0]  o_data_rom_map_ff,
   output reg  [1:0]  o_code_rom_map_ff,
   output reg         o_init_done_ff,
   output reg         o_data_rom_hit_ff,
   output reg         o_code_rom_hit_ff
);
   // *******************************************
   // Local state
   // *******************************************
   localparam [2:0] ST_RESET = 3'b001;
   localparam [2:0] ST_INIT  = 3'b010;
   localparam [2:0] ST_RUN   = 3'b100;

   reg  [2:0]  state_ff;
   reg  [2:0]  nxt_state;
   reg  [15:0] syscfg_ff;
   reg  [15:0] nxt_syscfg;
   reg  [1:0]  rom_map_ff;
   reg  [1:0]  nxt_rom_map;
   reg         nxt_ext_bus_en;
   reg  [1:0]  nxt_bus_mode;
   reg  [1:0]  lag_cnt_ff;
   reg  [1:0]  pend_map_ff;
   reg         code_pend_ff;
   reg  [15:0] nxt_rdata;

   wire        strap_bus_active_strap_n;
   wire [1:0]  strap_bus_type_field;
   wire        strap_load;
   wire        data_hit;
   wire        code_hit;
   wire        wr_sys;
   wire        wr_ctrl;
   wire        w_bus_active_strap_n;
   wire [1:0]  w_bus_type_field;
   wire [1:0]  dec_map  [0:1];
   wire [17:0] dec_addr [0:1];
   wire [1:0]  dec_hit;

   // *******************************************
   // Register port decode
   // *******************************************
   assign wr_sys   = i_wr && (i_addr == `BMRC_REG_SYSCFG);
   assign wr_ctrl  = i_wr && (i_addr == `BMRC_REG_CTRL);
   assign w_bus_active_strap_n = i_wdata[`BMRC_BUS_ACTIVE_STRAP_N_BIT];
   assign w_bus_type_field   = i_wdata[`BMRC_BUS_TYPE_FIELD_HI:`BMRC_BUS_TYPE_FIELD_LO];

   // *******************************************
   // Sub blocks
   // *******************************************
   bmrc_strap_cap u_strap
   (
      .i_ref_clk            (i_ref_clk),
      .i_rstn               (i_rstn),
      .i_bus_active_strap_n (i_bus_active_strap_n),
      .i_bus_cfg_strap0     (i_bus_cfg_strap0),
      .i_bus_cfg_strap1     (i_bus_cfg_strap1),
      .o_bus_active_strap_n_ff          (strap_bus_active_strap_n),
      .o_bus_type_field_ff            (strap_bus_type_field),
      .o_load_ff            (strap_load)
   );

   // Entry 0 decodes data lookups, entry 1 code fetches
   assign dec_map[0]  = o_data_rom_map_ff;
   assign dec_map[1]  = o_code_rom_map_ff;
   assign dec_addr[0] = i_data_addr;
   assign dec_addr[1] = i_code_addr;
   assign data_hit    = dec_hit[0];
   assign code_hit    = dec_hit[1];

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1)
      begin : g_dec
         bmrc_rom_decode u_rom_dec
         (
            .i_rom_map (dec_map[gi]),
            .i_addr    (dec_addr[gi]),
            .o_rom_hit (dec_hit[gi])
         );
      end
   endgenerate

   // *******************************************
   // Phase machine and configuration decode
   // *******************************************
   always @*
   begin
      nxt_state      = state_ff;
      nxt_syscfg     = syscfg_ff;
      nxt_rom_map    = rom_map_ff;
      nxt_ext_bus_en = o_ext_bus_en_ff;
      nxt_bus_mode   = o_bus_mode_ff;
      case (state_ff)
         ST_RESET:
         begin
            if (strap_load)
            begin
               nxt_syscfg = `BMRC_SYSCFG_RST;
               nxt_syscfg[`BMRC_BUS_ACTIVE_STRAP_N_BIT] = strap_bus_active_strap_n;
               nxt_syscfg[`BMRC_BUS_TYPE_FIELD_HI:`BMRC_BUS_TYPE_FIELD_LO] = strap_bus_type_field;
               if (strap_bus_active_strap_n)
               begin
                  // External start, mode straight from the straps
                  nxt_rom_map    = `BMRC_ROM_OFF;
                  nxt_ext_bus_en = 1'b1;
                  nxt_bus_mode   = strap_bus_type_field;
               end
               else
               begin
                  // Reserved combos fall into single chip as well
                  nxt_rom_map    = `BMRC_ROM_SEG0;
                  nxt_ext_bus_en = 1'b0;
                  nxt_bus_mode   = `BMRC_BT_8NMUX;
               end
               nxt_state = ST_INIT;
            end
         end
         ST_INIT, ST_RUN:
         begin
            if (wr_sys)
            begin
               nxt_syscfg[`BMRC_BUS_ACTIVE_STRAP_N_BIT] = w_bus_active_strap_n;
               nxt_syscfg[`BMRC_BUS_TYPE_FIELD_HI:`BMRC_BUS_TYPE_FIELD_LO] = w_bus_type_field;
               if (w_bus_active_strap_n)
               begin
                  nxt_ext_bus_en = 1'b1;
                  nxt_bus_mode   = w_bus_type_field;
               end
               else if (state_ff == ST_INIT)
               begin
                  // Bus mode untouched while the active bit is 0
                  case (w_bus_type_field)
                     `BMRC_BT_8NMUX: nxt_rom_map = `BMRC_ROM_SEG0;
                     `BMRC_BT_8MUX:  nxt_rom_map = `BMRC_ROM_SEG1;
                     `BMRC_BT_16MUX: nxt_rom_map = `BMRC_ROM_OFF;
                     default:        nxt_ext_bus_en = 1'b0;
                  endcase
               end
            end
            if (wr_ctrl && i_wdata[`BMRC_CTRL_END_OF_INIT_INSTRUCTION_BIT] && (state_ff == ST_INIT))
            begin
               nxt_state = ST_RUN;
            end
         end
         default:
         begin
            nxt_state = ST_RESET;
         end
      endcase
   end

   // *******************************************
   // Registers
   // *******************************************
   always @(posedge i_ref_clk)
   begin
      if (!i_rstn)
      begin
         state_ff        <= ST_RESET;
         syscfg_ff       <= `BMRC_SYSCFG_RST;
         rom_map_ff      <= `BMRC_ROM_SEG0;
         o_ext_bus_en_ff <= 1'b0;
         o_bus_mode_ff   <= 2'h0;
      end
      else
      begin
         state_ff        <= nxt_state;
         syscfg_ff       <= nxt_syscfg;
         rom_map_ff      <= nxt_rom_map;
         o_ext_bus_en_ff <= nxt_ext_bus_en;
         o_bus_mode_ff   <= nxt_bus_mode;
      end
   end

   // *******************************************
   // Boot source and phase flags
   // *******************************************
   // Boot source moves only on a strap load, so later writes cannot fake it
   always @(posedge i_ref_clk)
   begin
      if (!i_rstn)
      begin
         o_boot_internal_ff <= 1'b0;
         o_init_done_ff     <= 1'b0;
      end
      else
      begin
         o_init_done_ff <= (nxt_state == ST_RUN);
         if (strap_load)
         begin
            o_boot_internal_ff <= ~strap_bus_active_strap_n;
         end
      end
   end

   // *******************************************
   // Pipeline lag of the new ROM mapping
   // *******************************************
   // Data side waits two completed instructions after the write, not counting the writer.
   always @(posedge i_ref_clk)
   begin
      if (!i_rstn)
      begin
         o_data_rom_map_ff <= `BMRC_ROM_SEG0;
         pend_map_ff       <= `BMRC_ROM_SEG0;
         lag_cnt_ff        <= 2'h0;
      end
      else if (strap_load)
      begin
         o_data_rom_map_ff <= nxt_rom_map;
         pend_map_ff       <= nxt_rom_map;
         lag_cnt_ff        <= 2'h0;
      end
      else if (nxt_rom_map != rom_map_ff)
      begin
         pend_map_ff <= nxt_rom_map;
         lag_cnt_ff  <= `BMRC_DATA_LAG;
      end
      else if ((lag_cnt_ff != 2'h0) && i_instr_done)
      begin
         lag_cnt_ff <= lag_cnt_ff - 2'h1;
         if (lag_cnt_ff == 2'h1)
         begin
            o_data_rom_map_ff <= pend_map_ff;
         end
      end
   end

   // Code side holds the old map until an absolute branch is taken.
   always @(posedge i_ref_clk)
   begin
      if (!i_rstn)
      begin
         o_code_rom_map_ff <= `BMRC_ROM_SEG0;
         code_pend_ff      <= 1'b0;
      end
      else if (strap_load)
      begin
         o_code_rom_map_ff <= nxt_rom_map;
         code_pend_ff      <= 1'b0;
      end
      else if (wr_ctrl && i_wdata[`BMRC_CTRL_BRANCH_BIT] && code_pend_ff)
      begin
         o_code_rom_map_ff <= rom_map_ff;
         code_pend_ff      <= (nxt_rom_map != rom_map_ff);
      end
      else if (nxt_rom_map != rom_map_ff)
      begin
         code_pend_ff <= 1'b1;
      end
   end

   // *******************************************
   // Read port
   // *******************************************
   always @*
   begin
      nxt_rdata = 16'h0000;
      case (i_addr)
         `BMRC_REG_SYSCFG: nxt_rdata = syscfg_ff;
         `BMRC_REG_STATUS: nxt_rdata = {7'h00, code_pend_ff, lag_cnt_ff, rom_map_ff,
                                        o_bus_mode_ff, o_ext_bus_en_ff, o_init_done_ff};
         `BMRC_REG_DECODE: nxt_rdata = {10'h000, o_code_rom_map_ff, o_data_rom_map_ff,
                                        o_code_rom_hit_ff, o_data_rom_hit_ff};
         default:          nxt_rdata = 16'h0000;
      endcase
   end

   // Zero outside the answer cycle, so a stale word never reads as data
   always @(posedge i_ref_clk)
   begin
      if (!i_rstn)
      begin
         o_rdata <= 16'h0000;
      end
      else
      begin
         o_rdata <= i_rd ? nxt_rdata : 16'h0000;
      end
   end

   // *******************************************
   // Lookup results
   // *******************************************
   always @(posedge i_ref_clk)
   begin
      if (!i_rstn)
      begin
         o_data_rom_hit_ff <= 1'b0;
         o_code_rom_hit_ff <= 1'b0;
      end
      else
      begin
         o_data_rom_hit_ff <= data_hit;
         o_code_rom_hit_ff <= code_hit;
      end
   end
endmodule

// ===== bmrc_cfg_monitor.sv
`timescale 1ns/10ps
module bmrc_cfg_monitor
(
   // Clock and reset
   input wire        i_ref_clk,
   input wire        i_rstn,
   // Inputs
   input wire        i_bus_active_strap_n,
   input wire        i_bus_cfg_strap0,
   input wire        i_bus_cfg_strap1,
   input wire [3:0]  i_addr,
   input wire [15:0] i_wdata,
   input wire        i_wr,
   input wire        i_rd,
   input wire        i_instr_done,
   input wire [17:0] i_data_addr,
   // Outputs
   input wire [15:0] o_rdata,
   input wire        o_boot_internal_ff,
   input wire        o_ext_bus_en_ff,
   input wire [1:0]  o_bus_mode_ff,
   input wire [1:0]  o_data_rom_map_ff,
   input wire [1:0]  o_code_rom_map_ff,
   input wire        o_init_done_ff,
   input wire        o_data_rom_hit_ff
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rstn);
   wire sys_wr = i_wr && (i_addr == 4'h0);
   // *********
   // Sequences
   // *********
   sequence s_rel;
      $rose(i_rstn) ##2 1'b1;
   endsequence
   sequence s_wr_rd;
      sys_wr ##1 (i_rd && i_addr == 4'h0);
   endsequence
   property p_boot;
      s_rel |-> o_boot_internal_ff == $past(i_bus_active_strap_n, 2)
         && o_data_rom_map_ff == ($past(i_bus_active_strap_n, 2) ? 2'h0 : 2'h2);
   endproperty
   a_boot: assert property (p_boot) else $error("boot source wrong");
   property p_ext;
      s_rel ##0 !$past(i_bus_active_strap_n, 2) |-> o_ext_bus_en_ff
         && o_bus_mode_ff == $past({i_bus_cfg_strap1, i_bus_cfg_strap0}, 2);
   endproperty
   a_ext: assert property (p_ext) else $error("strap bus mode wrong");
   property p_mode;
      sys_wr && i_wdata[10] |=> o_ext_bus_en_ff && o_bus_mode_ff == $past(i_wdata[8:7]);
   endproperty
   a_mode: assert property (p_mode) else $error("bus mode not taken");
   property p_hold;
      sys_wr && !i_wdata[10] |=> $stable(o_bus_mode_ff);
   endproperty
   a_hold: assert property (p_hold) else $error("bus mode moved");
   property p_late;
      sys_wr && !i_wdata[10] && o_init_done_ff |=> $stable(o_ext_bus_en_ff);
   endproperty
   a_late: assert property (p_late) else $error("late write acted");
   property p_rback;
      s_wr_rd |=> o_rdata[10] == $past(i_wdata[10], 2)
         && o_rdata[8:7] == $past(i_wdata[8:7], 2);
   endproperty
   a_rback: assert property (p_rback) else $error("readback wrong");
   property p_lag;
      $changed(o_data_rom_map_ff) && $past(i_rstn, 3) |-> $past(i_instr_done);
   endproperty
   a_lag: assert property (p_lag) else $error("data map moved early");
   property p_code;
      $changed(o_code_rom_map_ff) && $past(i_rstn, 3)
         |-> $past(i_wr && i_addr == 4'h2 && i_wdata[1]);
   endproperty
   a_code: assert property (p_code) else $error("code map moved early");
   property p_hit;
      o_data_rom_map_ff == 2'h1 && $stable(o_data_rom_map_ff) |-> o_data_rom_hit_ff
         == ($past(i_data_addr) >= 18'h10000 && $past(i_data_addr) <= 18'h11fff);
   endproperty
   a_hit: assert property (p_hit) else $error("segment 1 decode wrong");
endmodule
bind bmrc_config bmrc_cfg_monitor u_bmrc_cfg_monitor (.*);

// ===== bmrc_board.sv
`timescale 1ns/10ps
module bmrc_board
(
   // Clock, reset, board wiring choice
   input  wire       i_ref_clk,
   input  wire       i_rstn,
   input  wire [2:0] i_combo,
   // Strap pins
   output wire       o_bus_active_strap_n,
   output wire       o_bus_cfg_strap1,
   output wire       o_bus_cfg_strap0
);
   reg live_ff = 1'b0;
   reg tgl_ff  = 1'b0;
   always @(posedge i_ref_clk)
   begin
      live_ff <= i_rstn;
      tgl_ff  <= ~tgl_ff;
   end
   // Wired levels only up to reset release, then churn to expose late sampling
   assign {o_bus_active_strap_n, o_bus_cfg_strap1, o_bus_cfg_strap0} =
      live_ff ? (i_combo ^ {3{~tgl_ff}}) : i_combo;
endmodule

// ===== bus_mode_rom_map_config_tb.sv
`timescale 1ns/10ps
module bus_mode_rom_map_config_tb;
   reg         clk = 1'b0;
   reg         rstn = 1'b0;
   reg  [2:0]  combo = 3'h0;
   reg  [3:0]  addr = 4'h0;
   reg  [15:0] wdata = 16'h0000;
   reg         wr = 1'b0;
   reg         rd = 1'b0;
   reg         instr = 1'b0;
   reg  [17:0] daddr = 18'h00000;
   reg         rd_seen = 1'b0;
   reg  [1:0]  t;
   reg  [31:0] rnd;
   reg  [15:0] expq[$];
   wire        sn, c0, c1, boot, ext_en, init_done, dhit, chit;
   wire [1:0]  mode, dmap, cmap;
   wire [15:0] rdata;
   integer     n_fail = 0;
   integer     comparisons = 0;
   integer     seed = 32'h9f31;
   integer     k;
   bmrc_board u_bmrc_board (.i_ref_clk(clk), .i_rstn(rstn), .i_combo(combo),
      .o_bus_active_strap_n(sn), .o_bus_cfg_strap1(c1), .o_bus_cfg_strap0(c0));
   bmrc_config u_bmrc_config (.i_ref_clk(clk), .i_rstn(rstn), .i_bus_active_strap_n(sn),
      .i_bus_cfg_strap0(c0), .i_bus_cfg_strap1(c1), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_instr_done(instr), .i_data_addr(daddr),
      .i_code_addr(daddr), .o_boot_internal_ff(boot), .o_ext_bus_en_ff(ext_en),
      .o_bus_mode_ff(mode), .o_data_rom_map_ff(dmap), .o_code_rom_map_ff(cmap),
      .o_init_done_ff(init_done), .o_data_rom_hit_ff(dhit), .o_code_rom_hit_ff(chit));
   initial forever #12.5 clk = ~clk;
   // **************
   // Bench plumbing
   // **************
   task results;
      begin
         $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
         if (n_fail == 0 && comparisons > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   task chk(input [15:0] seen, input [15:0] exp);
      begin
         comparisons = comparisons + 1;
         if (seen !== exp)
         begin
            n_fail = n_fail + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   function [15:0] sc(input b, input [1:0] bt);
      sc = {5'h00, b, 1'b0, bt, 7'h00};
   endfunction
   task wr_reg(input [3:0] a, input [15:0] d);
      begin
         @(posedge clk);
         wr <= 1'b1;
         addr <= a;
         wdata <= d;
         @(posedge clk);
         wr <= 1'b0;
         @(negedge clk);
      end
   endtask
   task rd_reg(input [3:0] a, input [15:0] e);
      begin
         @(posedge clk);
         rd <= 1'b1;
         addr <= a;
         expq.push_back(e);
         @(posedge clk);
         rd <= 1'b0;
      end
   endtask
   task wr_rd(input [15:0] d);
      begin
         @(posedge clk);
         wr <= 1'b1;
         addr <= 4'h0;
         wdata <= d;
         @(posedge clk);
         wr <= 1'b0;
         rd <= 1'b1;
         expq.push_back(d);
         @(posedge clk);
         rd <= 1'b0;
         @(negedge clk);
      end
   endtask
   always @(posedge clk) rd_seen <= rd;
   always @(negedge clk)
      if (rd_seen)
         chk(rdata, expq.pop_front());
   task pulse;
      begin
         @(posedge clk);
         instr <= 1'b1;
         @(posedge clk);
         instr <= 1'b0;
         @(negedge clk);
      end
   endtask
   task hit(input [17:0] a, input [1:0] m);
      reg e;
      begin
         e = m == 2'h0 ? a < 18'h02000 : m == 2'h1 && a >= 18'h10000 && a < 18'h12000;
         @(posedge clk);
         daddr <= a;
         @(posedge clk);
         @(negedge clk);
         chk(dhit, e);
         chk(chit, e);
      end
   endtask
   task do_reset(input [2:0] c);
      begin
         @(posedge clk);
         combo <= c;
         rstn <= 1'b0;
         repeat (5) @(posedge clk);
         rstn <= 1'b1;
         repeat (2) @(posedge clk);
         @(negedge clk);
      end
   endtask
   initial
   begin
      repeat (20000) @(posedge clk);
      n_fail = n_fail + 1;
      results;
   end
   initial
   begin
      for (k = 0; k < 8; k = k + 1)
      begin
         do_reset(k[2:0]);
         chk(boot, k[2]);
         chk(ext_en, !k[2]);
         if (!k[2])
            chk(mode, k[1:0]);
         chk(dmap, k[2] ? 2'h0 : 2'h2);
         rd_reg(4'h0, sc(!k[2], k[1:0]));
      end
      rd_reg(4'hf, 16'h0000);
      $display("Strap test done");
      do_reset(3'h4);
      rnd = $random(seed);
      t = rnd[1:0];
      wr_reg(4'h0, sc(1'b1, t));
      chk(mode, t);
      rd_reg(4'h0, sc(1'b1, t));
      hit(18'h3ffff, 2'h0);
      wr_reg(4'h0, sc(1'b0, 2'h1));
      pulse;
      chk(dmap, 2'h0);
      pulse;
      chk(dmap, 2'h1);
      chk(cmap, 2'h0);
      wr_reg(4'h2, 16'h0002);
      chk(cmap, 2'h1);
      chk(mode, t);
      hit(18'h0ffff, 2'h1);
      hit(18'h10000, 2'h1);
      hit(18'h11fff, 2'h1);
      hit(18'h12000, 2'h1);
      rnd = $random(seed);
      hit({5'h08, rnd[12:0]}, 2'h1);
      $display("Remap test done");
      hit(18'h3ffff, 2'h1);
      wr_reg(4'h0, sc(1'b0, 2'h2));
      pulse;
      pulse;
      wr_reg(4'h2, 16'h0002);
      hit(18'h10000, 2'h2);
      wr_reg(4'h0, sc(1'b0, 2'h3));
      chk(ext_en, 1'b0);
      $display("Disable test done");
      wr_reg(4'h2, 16'h0001);
      chk(init_done, 1'b1);
      wr_reg(4'h0, sc(1'b0, 2'h0));
      pulse;
      pulse;
      wr_reg(4'h2, 16'h0002);
      chk(dmap, 2'h2);
      chk(cmap, 2'h2);
      rnd = $random(seed);
      t = rnd[1:0];
      wr_reg(4'h0, sc(1'b1, t));
      chk(mode, t);
      wr_reg(4'h0, sc(1'b0, 2'h3));
      chk(ext_en, 1'b1);
      t = ~t;
      wr_rd(sc(1'b1, t));
      chk(mode, t);
      $display("Lock test done");
      repeat (2) @(posedge clk);
      results;
   end
endmodule
